// File: inc/aps_pkg.sv
// package for the async page psram host controller
`default_nettype none
package aps_pkg;
	// ************************************************************
	// widths
	// ************************************************************
	localparam int APS_AW = 22;
	localparam int APS_DW = 16;
	// ************************************************************
	// timing (125 MHz, 8 ns)
	// ************************************************************
	localparam int CLK_PERIOD_PS   = 8000;
	localparam int INIT_TIME_NS    = 150000;
	localparam int SLEEP_MIN_NS    = 10000;
	localparam int ACCESS_TIME_NS  = 70;
	localparam int PAGE_TIME_NS    = 20;
	localparam int SEL_MAX_NS      = 4000;
	localparam int INIT_CYC  = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SLEEP_CYC = (SLEEP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int ACC_CYC   = (ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PAGE_CYC  = (PAGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SEL_MAX_CYC = (SEL_MAX_NS * 1000) / CLK_PERIOD_PS;
	// ************************************************************
	// configuration word layout
	// ************************************************************
	localparam logic [15:0] CFG_RESET     = 16'h0010;
	localparam int          CFG_SLEEP_BIT = 4;
	localparam int          CFG_PAGE_BIT  = 7;
	localparam int          PAGE_LSB      = 4;
	// ************************************************************
	// commands and pins
	// ************************************************************
	typedef enum logic [1:0] {
		APS_CMD_READ  = 2'h0,
		APS_CMD_WRITE = 2'h1,
		APS_CMD_CFG   = 2'h2,
		APS_CMD_SLEEP = 2'h3
	} aps_cmd_t;
	typedef struct packed {
		aps_cmd_t            cmd;
		logic [APS_AW-1:0]   addr;
		logic [APS_DW-1:0]   wdata;
		logic [1:0]          be;
	} aps_req_t;
	typedef struct packed {
		logic                chip_sel_n;
		logic                out_drv_n;
		logic                wr_strobe_n;
		logic                low_byte_strobe_n;
		logic                high_byte_strobe_n;
		logic                sleep_request_n;
		logic [APS_AW-1:0]   addr;
		logic [APS_DW-1:0]   dq_out;
		logic                dq_oe;
	} aps_pins_t;
endpackage : aps_pkg
`default_nettype wire

// File: hw/aps_sync3.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module aps_sync3 #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} aps_sync_t;
	aps_sync_t st_r;
	aps_sync_t st_nxt;
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// change counts only once stage two and three agree
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign dout = st_r.q;
endmodule // aps_sync3
`default_nettype wire

// File: hw/aps_host.sv
// host-side controller driving the async page psram pins
// Notes on behaviour
// [RQ1] device self-initialises after power up; host waits the init time first
// [RQ2] chip select held high during the whole initialisation period
// [RQ3] bus starts in plain asynchronous mode after power up
// [RQ4] read: select, output drive, byte strobes low, write strobe high
// [RQ5] write: select, write strobe, byte strobes low; output drive kept high
// [RQ6] write data held stable until strobes rise together
// [RQ7] select and write strobe never held low beyond the maximum time
// [RQ8] page reads shorten the wait when only address bits 3:0 change
// [RQ9] byte strobes low only for lanes to be written
// [RQ10] both byte strobes low during every read
// [RQ11] both strobes high keeps data bus idle though selected
// [RQ12] standby whenever select and sleep pin are both high
// [RQ13] device drops power after access; host returns pins to idle
// [RQ14] partial refresh may lose unrefreshed data
// [RQ15] no reads or writes issued while sleeping
// [RQ16] partial refresh entered by holding sleep low beyond minimum time
// [RQ17] sleep pin high leaves partial refresh at once
// [RQ18] software sequence setting sleep bit starts partial refresh
// [RQ19] after software config write, sleep low no longer starts partial refresh
// [RQ20] deep sleep entered by sleep low with sleep bit zero
// [RQ21] leaving deep sleep needs a new initialisation period
// [RQ22] configuration word defaults to 0010h
// [RQ23] configuration bit 7 enables page reads
// [RQ24] bits 2:0 select the refreshed part of the array
// [RQ25] sleep low plus write loads configuration from the address pins
// [RQ26] sleep pin kept high during normal reads and writes
`default_nettype none
module aps_host
	import aps_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYC
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// user request
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire aps_pkg::aps_req_t req,
	input  wire logic              wake,
	// user answer
	output logic                   rsp_valid,
	output logic [15:0]            rsp_rdata,
	output logic                   asleep,
	output logic [15:0]            cfg_shadow,
	// device pins
	output aps_pkg::aps_pins_t     pins,
	input  wire logic [15:0]       dq_in
);
	import aps_pkg::*;
	initial begin
		if (INIT_CYCLES < 1) begin
			$error("INIT_CYCLES must be at least one");
		end
	end
	// ************************************************************
	// state
	// ************************************************************
	typedef enum logic [6:0] {
		S_INIT  = 7'h01,
		S_IDLE  = 7'h02,
		S_RD    = 7'h04,
		S_WR    = 7'h08,
		S_CFG   = 7'h10,
		S_SLEEP = 7'h20,
		S_REC   = 7'h40
	} aps_state_t;
	typedef struct packed {
		aps_state_t  st;
		logic [17:0] cnt;
		logic [15:0] cfg;
		logic        deep;
		logic        page_ok;
		logic [17:0] page_tag;
		logic        rsp;
		logic [15:0] rdata;
		aps_pins_t   p;
	} aps_host_t;
	aps_host_t r_r;
	aps_host_t r_nxt;
	logic [15:0] dq_sync;
	// pin input crosses from the device; settled data only reaches the host
	aps_sync3 #(.W(16)) u_dq_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.din     (dq_in),
		.dout    (dq_sync)
	);
	function automatic aps_pins_t idle_pins(input aps_pins_t p);
		aps_pins_t q;
		q                    = p;
		q.chip_sel_n         = 1'b1;
		q.out_drv_n          = 1'b1;
		q.wr_strobe_n        = 1'b1;
		q.low_byte_strobe_n  = 1'b1;
		q.high_byte_strobe_n = 1'b1;
		q.sleep_request_n    = 1'b1;
		q.dq_oe              = 1'b0;
		return q;
	endfunction
	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		r_nxt     = r_r;
		r_nxt.rsp = 1'b0;
		case (r_r.st)
			S_INIT: begin
				r_nxt.p = idle_pins(r_r.p); // [RQ2]
				if (r_r.cnt == 18'(INIT_CYCLES - 1)) begin
					r_nxt.st  = S_IDLE; // [RQ1] [RQ21]
					r_nxt.cnt = '0;
				end else begin
					r_nxt.cnt = r_r.cnt + 18'h1;
				end
			end
			S_IDLE: begin
				r_nxt.p   = idle_pins(r_r.p); // [RQ12] [RQ13] [RQ26]
				r_nxt.cnt = '0;
				if (req_valid) begin
					r_nxt.p.addr = req.addr;
					case (req.cmd)
						APS_CMD_READ: begin
							r_nxt.st                   = S_RD;
							r_nxt.p.chip_sel_n         = 1'b0; // [RQ4]
							r_nxt.p.out_drv_n          = 1'b0;
							r_nxt.p.low_byte_strobe_n  = 1'b0; // [RQ10]
							r_nxt.p.high_byte_strobe_n = 1'b0;
						end
						APS_CMD_WRITE: begin
							r_nxt.st                   = S_WR;
							r_nxt.p.chip_sel_n         = 1'b0; // [RQ5]
							r_nxt.p.wr_strobe_n        = 1'b0;
							r_nxt.p.low_byte_strobe_n  = ~req.be[0]; // [RQ9] [RQ11]
							r_nxt.p.high_byte_strobe_n = ~req.be[1];
							r_nxt.p.dq_out             = req.wdata;
							r_nxt.p.dq_oe              = 1'b1;
						end
						APS_CMD_CFG: begin
							r_nxt.st                = S_CFG;
							r_nxt.p.sleep_request_n = 1'b0; // [RQ25]
							r_nxt.p.chip_sel_n      = 1'b0;
							r_nxt.p.wr_strobe_n     = 1'b0;
							// loads only through the sleep pin, so it keeps its low-power role
							r_nxt.cfg               = req.addr[15:0]; // [RQ18] [RQ19]
							r_nxt.page_ok           = 1'b0;
						end
						default: begin
							r_nxt.st                = S_SLEEP;
							r_nxt.p.sleep_request_n = 1'b0; // [RQ16] [RQ20]
							r_nxt.deep              = ~r_r.cfg[CFG_SLEEP_BIT];
						end
					endcase
				end
			end
			S_RD: begin
				r_nxt.cnt = r_r.cnt + 18'h1;
				// short wait only inside an already opened page
				// four more cycles cover the pin synchroniser latency
				if ((r_r.cnt == 18'(ACC_CYC + 4)) || (r_r.page_ok && r_r.cfg[CFG_PAGE_BIT] &&
				    r_r.page_tag == r_r.p.addr[APS_AW-1:PAGE_LSB] &&
				    r_r.cnt == 18'(PAGE_CYC + 4))) begin // [RQ8] [RQ23] [RQ3]
					r_nxt.rdata    = dq_sync;
					r_nxt.rsp      = 1'b1;
					r_nxt.page_ok  = 1'b1;
					r_nxt.page_tag = r_r.p.addr[APS_AW-1:PAGE_LSB];
					r_nxt.st       = S_IDLE;
					r_nxt.p        = idle_pins(r_r.p); // [RQ7]
				end
			end
			S_WR, S_CFG: begin
				r_nxt.cnt = r_r.cnt + 18'h1;
				if (r_r.cnt == 18'(ACC_CYC)) begin
					// all strobes rise together, data held one more cycle
					r_nxt.p.chip_sel_n         = 1'b1; // [RQ6] [RQ7]
					r_nxt.p.wr_strobe_n        = 1'b1;
					r_nxt.p.low_byte_strobe_n  = 1'b1;
					r_nxt.p.high_byte_strobe_n = 1'b1;
				end else if (r_r.cnt == 18'(ACC_CYC + 1)) begin
					r_nxt.p   = idle_pins(r_r.p);
					r_nxt.rsp = 1'b1;
					r_nxt.st  = S_IDLE;
					r_nxt.page_ok = 1'b0;
				end
			end
			S_SLEEP: begin
				// no access is issued until woken [RQ15] [RQ14]
				if (r_r.cnt != 18'(SLEEP_CYC)) begin
					r_nxt.cnt = r_r.cnt + 18'h1;
				end else if (wake) begin
					r_nxt.p.sleep_request_n = 1'b1; // [RQ17]
					r_nxt.cnt     = '0;
					r_nxt.page_ok = 1'b0;
					r_nxt.st      = r_r.deep ? S_INIT : S_REC; // [RQ21]
				end
			end
			S_REC: begin
				r_nxt.st = S_IDLE;
			end
			default: begin
				r_nxt.st = S_INIT;
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r_r       <= '0;
			r_r.st    <= S_INIT;
			r_r.cfg   <= CFG_RESET; // [RQ22] [RQ24]
			r_r.p.chip_sel_n         <= 1'b1;
			r_r.p.out_drv_n          <= 1'b1;
			r_r.p.wr_strobe_n        <= 1'b1;
			r_r.p.low_byte_strobe_n  <= 1'b1;
			r_r.p.high_byte_strobe_n <= 1'b1;
			r_r.p.sleep_request_n    <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end
	assign req_ready  = (r_r.st == S_IDLE);
	assign rsp_valid  = r_r.rsp;
	assign rsp_rdata  = r_r.rdata;
	assign asleep     = (r_r.st == S_SLEEP);
	assign cfg_shadow = r_r.cfg;
	assign pins       = r_r.p;
	// ************************************************************
	// checks
	// ************************************************************
	chk_init_select_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(r_r.st == S_INIT) |-> pins.chip_sel_n) else $error("select low in init"); // [RQ2]
	chk_read_strobes: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!pins.chip_sel_n && pins.wr_strobe_n) |-> (!pins.low_byte_strobe_n &&
		!pins.high_byte_strobe_n && !pins.out_drv_n)) else $error("read strobe"); // [RQ10]
	chk_write_no_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!pins.wr_strobe_n |-> pins.out_drv_n && pins.dq_oe == pins.sleep_request_n)
		else $error("write with output drive"); // [RQ5]
	chk_select_bounded: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(pins.chip_sel_n) |-> ##[1:20] pins.chip_sel_n)
		else $error("select held too long"); // [RQ7]
	chk_data_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(pins.wr_strobe_n) |-> $stable(pins.dq_out) && $stable(pins.addr))
		else $error("data moved at strobe rise"); // [RQ6]
	chk_sleep_pin_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!pins.chip_sel_n && pins.wr_strobe_n) |-> pins.sleep_request_n)
		else $error("sleep low during read"); // [RQ26]
	sequence seq_sleep_start;
		$fell(pins.sleep_request_n) && pins.chip_sel_n;
	endsequence
	chk_sleep_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
		seq_sleep_start |-> pins.chip_sel_n [*8]) else $error("access while asleep"); // [RQ15]
	chk_init_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(r_r.st == S_INIT && r_r.cnt == 18'h0) |-> ##1 (r_r.st == S_INIT))
		else $error("init too short"); // [RQ1]
endmodule // aps_host
`default_nettype wire

// File: dv/aps_psram_model.sv
// behavioural psram answering the host controller pins
`default_nettype none
module aps_psram_model
	import aps_pkg::*;
#(
	parameter int INIT_NS = 150000
) (
	// device pins
	input  wire aps_pkg::aps_pins_t pins,
	output logic [15:0]             dq_in,
	// host faults seen
	output var int                  viol
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// array, config and timing state
	// ********
	logic [15:0] mem [int];
	logic [15:0] cfg = CFG_RESET;
	logic [15:0] hold = 16'h0000;
	logic [15:0] wd, w;
	logic [21:0] ra, wa;
	logic [1:0]  wl;
	logic        dv = 1'b0, rd = 1'b0, rd_q = 1'b0, arm = 1'b0;
	realtime     rdy_t = INIT_NS, zz_t = 0, cs_t = 0;
	int          seq = 0, pg = -1, q[$];
	function automatic bit live();
		return $realtime >= rdy_t && (pins.sleep_request_n || $realtime - zz_t < 10000);
	endfunction
	function automatic bit kept(int a);
		int s = 'h400000 >> cfg[1:0];
		return cfg[2] ? cfg[1:0] != 0 && a >= 'h400000 - s : a < s;
	endfunction
	task automatic upd();
		w = mem.exists(ra) ? mem[ra] : 16'h5A5A;
		// released lines never keep their last level
		dq_in = ~hold;
		if (pins.dq_oe) dq_in = pins.dq_out;
		if (dv && !pins.low_byte_strobe_n) dq_in[7:0] = w[7:0];
		if (dv && !pins.high_byte_strobe_n) dq_in[15:8] = w[15:8];
		hold = dq_in;
	endtask
	always @(pins) begin
		rd = !pins.chip_sel_n && !pins.out_drv_n && pins.wr_strobe_n && live();
		if (rd !== rd_q || pins.addr !== ra) begin
			dv = 1'b0;
			seq++;
			ra = pins.addr;
			if (rd) fork
				automatic int s = seq;
				automatic int d = (cfg[7] && pins.addr[21:4] == pg) ? 20 : 70;
				begin
					#(d);
					if (s == seq) begin
						dv = 1'b1;
						pg = ra[21:4];
						upd();
					end
				end
			join_none
		end
		rd_q = rd;
		if (!pins.wr_strobe_n) pg = -1;
		upd();
		if (!pins.chip_sel_n && !pins.wr_strobe_n) begin
			arm = 1'b1;
			wa = pins.addr;
			wd = dq_in;
			wl = {pins.high_byte_strobe_n, pins.low_byte_strobe_n};
		end
	end
	always @(posedge pins.chip_sel_n or posedge pins.wr_strobe_n) begin
		if (arm && !pins.sleep_request_n) cfg = wa[15:0];
		else if (arm && live() && wl != 2'b11) begin
			w = mem.exists(wa) ? mem[wa] : 16'h5A5A;
			if (!wl[0]) w[7:0] = wd[7:0];
			if (!wl[1]) w[15:8] = wd[15:8];
			mem[wa] = w;
		end
		arm = 1'b0;
	end
	always @(negedge pins.sleep_request_n) zz_t = $realtime;
	always @(posedge pins.sleep_request_n) begin
		if ($realtime - zz_t > 10000 && cfg[4]) begin
			q = {};
			foreach (mem[a]) if (!kept(a)) q.push_back(a);
			foreach (q[i]) mem.delete(q[i]);
		end else if ($realtime - zz_t > 10000) begin
			mem.delete();
			rdy_t = $realtime + INIT_NS;
		end
	end
	initial viol = 0;
	always @(negedge pins.chip_sel_n) begin
		cs_t = $realtime;
		if ($realtime < rdy_t) viol++;
	end
	always @(posedge pins.chip_sel_n) if ($realtime - cs_t > SEL_MAX_NS) viol++;
endmodule // aps_psram_model
`default_nettype wire

// File: dv/tb_async_page_psram_interface.sv
// self-checking bench for the async page psram host controller
`default_nettype none
module tb_async_page_psram_interface
	import aps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// design, model and checks
	// ********
	logic        sys_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, wake = 1'b0;
	logic        req_ready, rsp_valid, asleep;
	logic [15:0] rsp_rdata, cfg_shadow, dq_in, rd;
	logic [5:0]  ctl;
	aps_req_t    req = '0;
	aps_pins_t   pins;
	int          bad_count = 0, check_count = 0, viol, lat;
	aps_host #(.INIT_CYCLES(20)) i_aps_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .wake(wake),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .asleep(asleep),
		.cfg_shadow(cfg_shadow), .pins(pins), .dq_in(dq_in));
	aps_psram_model #(.INIT_NS(150)) i_aps_psram_model (.pins(pins), .dq_in(dq_in),
		.viol(viol));
	initial forever #4 sys_clk = ~sys_clk;
	// two sleeps of about 1300 cycles dominate; 12500 cycles (100 us) is ample
	initial begin
		#100us;
		bad_count++;
		final_report();
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic op(input aps_cmd_t c, input logic [21:0] a, input logic [15:0] d,
			input logic [1:0] b);
		@(negedge sys_clk);
		req_valid = 1'b1;
		req = '{c, a, d, b};
		for (int k = 0; k < 40000 && req_ready !== 1'b1; k++) @(negedge sys_clk);
		@(negedge sys_clk);
		req_valid = 1'b0;
		lat = 0;
		while (c != APS_CMD_SLEEP && lat < 100 && !(lat > 0 && rsp_valid)) begin
			@(posedge sys_clk);
			lat++;
			@(negedge sys_clk);
			if (lat == 1) ctl = {pins.chip_sel_n, pins.out_drv_n, pins.wr_strobe_n,
				pins.low_byte_strobe_n, pins.high_byte_strobe_n, pins.sleep_request_n};
		end
		rd = rsp_rdata;
	endtask
	task automatic t_rw();
		op(APS_CMD_WRITE, 22'h000123, 16'hA5C3, 2'b11);
		check({10'h000, ctl}, 16'h0011);
		check(lat[15:0], 16'h000B);
		op(APS_CMD_READ, 22'h000123, 16'h0000, 2'b11);
		check({10'h000, ctl}, 16'h0009);
		check(rd, 16'hA5C3);
		op(APS_CMD_WRITE, 22'h000123, 16'h1111, 2'b01);
		check({10'h000, ctl}, 16'h0013);
		op(APS_CMD_WRITE, 22'h000123, 16'h2222, 2'b10);
		op(APS_CMD_WRITE, 22'h000123, 16'h3333, 2'b00);
		check({10'h000, ctl}, 16'h0017);
		op(APS_CMD_READ, 22'h000123, 16'h0000, 2'b11);
		check(rd, 16'h2211);
	endtask
	task automatic t_page();
		op(APS_CMD_CFG, 22'h000091, 16'h0000, 2'b00);
		check({10'h000, ctl & 6'h29}, 16'h0000);
		check(cfg_shadow, 16'h0091);
		op(APS_CMD_WRITE, 22'h000120, 16'hBEEF, 2'b11);
		op(APS_CMD_READ, 22'h000120, 16'h0000, 2'b11);
		check(lat[15:0], 16'(ACC_CYC + 5));
		op(APS_CMD_READ, 22'h000123, 16'h0000, 2'b11);
		check(lat[15:0], 16'(PAGE_CYC + 5));
		check(rd, 16'h2211);
		op(APS_CMD_READ, 22'h000133, 16'h0000, 2'b11);
		check(lat[15:0], 16'(ACC_CYC + 5));
	endtask
	task automatic t_sleep(input logic [15:0] cfg, input logic deep);
		int n;
		logic sel;
		n = 0;
		sel = 1'b0;
		op(APS_CMD_CFG, {6'h00, cfg}, 16'h0000, 2'b00);
		op(APS_CMD_WRITE, 22'h300000, 16'h7777, 2'b11);
		op(APS_CMD_SLEEP, 22'h000000, 16'h0000, 2'b00);
		wake = 1'b1;
		for (int k = 0; k < 5000 && (n == 0 || !pins.sleep_request_n); k++) begin
			@(negedge sys_clk);
			if (!pins.sleep_request_n) begin
				n++;
				sel |= !pins.chip_sel_n | !asleep;
			end
		end
		wake = 1'b0;
		check({15'h0000, sel}, 16'h0000);
		check({15'h0000, n * 8 > 10000}, 16'h0001);
		if (deep) check({15'h0000, req_ready}, 16'h0000);
		op(APS_CMD_READ, 22'h000120, 16'h0000, 2'b11);
		check({15'h0000, rd === 16'hBEEF}, {15'h0000, ~deep});
		op(APS_CMD_READ, 22'h300000, 16'h0000, 2'b11);
		check({15'h0000, rd === 16'h7777}, 16'h0000);
	endtask
	initial begin
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		check({15'h0000, req_ready}, 16'h0000);
		check({15'h0000, pins.chip_sel_n}, 16'h0001);
		check(cfg_shadow, 16'h0010);
		t_rw();
		t_page();
		t_sleep(16'h0091, 1'b0);
		t_sleep(16'h0000, 1'b1);
		check(viol[15:0], 16'h0000);
		final_report();
	end
endmodule // tb_async_page_psram_interface
`default_nettype wire
